// ### rtl/host_port_pkg.sv
// Shared constants for the processor bus port of the serial controller
package host_port_pkg;
	// ----------------------------------------
	// Pin order inside the synchronised vector
	// ----------------------------------------
	localparam int PIN_W = 7;
	localparam int P_CS = 0;
	localparam int P_RD = 1;
	localparam int P_WR = 2;
	localparam int P_DC = 3;
	localparam int P_AB = 4;
	localparam int P_ACK = 5;
	localparam int P_CHAIN = 6;
	// ----------------------------------------
	// Register indices behind the pointer
	// ----------------------------------------
	localparam logic [3:0] IDX_CMD = 4'h0;
	localparam logic [3:0] IDX_VEC = 4'h2;
	localparam logic [3:0] IDX_PEND = 4'h3;
	localparam logic [3:0] IDX_BUF = 4'h8;
	localparam logic [3:0] IDX_MIC = 4'h9;
	// ----------------------------------------
	// Command byte fields
	// ----------------------------------------
	localparam int CMD_LO = 3;
	localparam int CMD_HI = 5;
	localparam logic [2:0] CMD_POINT_HIGH = 3'h1;
	localparam logic [2:0] CMD_RESET_SVC = 3'h7;
	// ----------------------------------------
	// Master interrupt control fields and resets
	// ----------------------------------------
	localparam int MIC_VIS = 0;
	localparam int MIC_DLC = 2;
	localparam int MIC_MIE = 3;
	localparam logic [7:0] MIC_RESET = 8'h00;
	localparam logic [7:0] VEC_RESET = 8'h00;
	// ----------------------------------------
	// Interrupt sources and timing
	// ----------------------------------------
	localparam int NSRC = 6;
	localparam logic [5:0] PEND_RESET = 6'h00;
	localparam int CLK_PERIOD_NS = 5;
	localparam logic [2:0] RECOV_CYCLES = 3'h4;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_XFER = 2'b01,
		ST_HOLD = 2'b10
	} port_state_t;
endpackage : host_port_pkg

// ### rtl/pin_lvl_if.sv
// Synchronised pin levels passed from the input stage to the port logic
interface pin_lvl_if;
	logic [6:0] lvl;
	modport src(output lvl);
	modport dst(input lvl);
endinterface : pin_lvl_if

// ### rtl/pin_sync.sv
// Three-stage synchroniser for the asynchronous bus pins
module pin_sync
	import host_port_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Raw pins
	input wire logic [PIN_W-1:0] pins,
	// Clean levels
	pin_lvl_if.src out
);
	logic [PIN_W-1:0] s1_r;
	logic [PIN_W-1:0] s2_r;
	logic [PIN_W-1:0] s3_r;
	logic [PIN_W-1:0] lvl_r;
	logic [PIN_W-1:0] agree;
	logic [PIN_W-1:0] lvl_nxt;

	// Idle pins are high; a bit moves only when stages two and three agree
	assign agree = ~(s2_r ^ s3_r);
	assign lvl_nxt = (agree & s2_r) | (~agree & lvl_r);

	always_ff @(posedge clk) begin
		if (rst) begin
			s1_r <= '1;
			s2_r <= '1;
			s3_r <= '1;
			lvl_r <= '1;
		end else begin
			s1_r <= pins;
			s2_r <= s1_r;
			s3_r <= s2_r;
			lvl_r <= lvl_nxt;
		end
	end

	assign out.lvl = lvl_r;
endmodule : pin_sync

// ### rtl/host_port.sv
// Processor bus port: strobes, pointer, shared registers, acknowledge
//
// Contract
// - Chip select with a strobe latches channel and data select, starts access.
// - Bus clock sets pending bits, independent of host strobes.
// - Four bus clocks from strobe fall before the next access.
// - Outside acknowledge, strobes are ignored until chip select is active.
// - Data drivers on only while read is low with chip select, or with acknowledge once it is won.
// - Data-select high keeps pointer; control access clears it afterwards.
// - Acknowledge sampled on clock; while low ignore selects and write.
// - Won acknowledge sets in-service bit and drives the vector.
// - Setting in-service on acknowledge drops the interrupt request.
// - Pending bits update at half rate, frozen while pointing at 2 or 3.
// - One pointer for both channels, loaded through either channel.
// - Next control access uses pointer, then pointer returns to zero.
// - Data-select high reaches the data buffer in one cycle.
// - Pointer is command bits 2..0, command may share the write.
// - Registers 8..15 need point-high with the pointer bits.
// - Channel comes from channel select of the actual access.
// - Vector and master interrupt control are shared by both channels.
module host_port
	import host_port_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Bus pins
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic dc_sel,
	input wire logic ab_sel,
	input wire logic irq_acknowledge_n,
	input wire logic chain_enable_in,
	input wire logic [7:0] d_in,
	output logic [7:0] d_out,
	output logic d_oe,
	output logic irq_n,
	output logic chain_enable_out,
	// Channel register side
	output logic reg_rd,
	output logic reg_wr,
	output logic [3:0] reg_index,
	output logic reg_chan,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	// Interrupt sources and state
	input wire logic [NSRC-1:0] irq_src,
	output logic [NSRC-1:0] irq_pending_bits,
	output logic [NSRC-1:0] irq_in_service
);
	// ----------------------------------------
	// Pin synchroniser
	// ----------------------------------------
	pin_lvl_if pl();
	logic [PIN_W-1:0] pins;
	assign pins = {chain_enable_in, irq_acknowledge_n, ab_sel, dc_sel, wr_n, rd_n, cs_n};

	pin_sync u_sync (
		.clk(clk),
		.rst(rst),
		.pins(pins),
		.out(pl.src)
	);

	logic cs_a;
	logic rd_a;
	logic wr_a;
	logic ack_a;
	logic dc;
	logic ab;
	logic chain_in;
	assign cs_a = ~pl.lvl[P_CS];
	assign rd_a = ~pl.lvl[P_RD];
	assign wr_a = ~pl.lvl[P_WR];
	assign ack_a = ~pl.lvl[P_ACK];
	assign dc = pl.lvl[P_DC];
	assign ab = pl.lvl[P_AB];
	assign chain_in = pl.lvl[P_CHAIN];

	// ----------------------------------------
	// State
	// ----------------------------------------
	port_state_t st_r;
	logic [2:0] rec_r;
	logic [3:0] ptr_r;
	logic clr_ptr_r;
	logic ext_rd_r;
	logic ack_drv_r;
	logic [7:0] vec_r;
	logic [7:0] mic_r;
	logic tick_r;
	logic [NSRC-1:0] pend_r;
	logic [NSRC-1:0] svc_r;
	logic [7:0] dout_r;
	logic doe_r;
	logic irqn_r;
	logic ceo_r;
	logic rrd_r;
	logic rwr_r;
	logic [3:0] ridx_r;
	logic rch_r;
	logic [7:0] rwd_r;

	// ----------------------------------------
	// Priority helpers
	// ----------------------------------------
	function automatic logic [2:0] top_of(input logic [NSRC-1:0] v);
		logic [2:0] r;
		r = 3'h0;
		for (int i = 0; i < NSRC; i++) begin
			if (v[i]) begin
				r = 3'(i);
			end
		end
		return r;
	endfunction : top_of

	function automatic logic [NSRC-1:0] onehot(input logic [2:0] i);
		return NSRC'(1) << i;
	endfunction : onehot

	// ----------------------------------------
	// Access decode
	// ----------------------------------------
	logic idle_ok;
	logic go_bus;
	logic go_ack;
	logic go;
	logic is_wr;
	logic [3:0] idx;
	logic ph;
	logic [3:0] ptr_load;
	logic wr_cmd;
	logic int_rd;
	logic [7:0] int_data;
	logic [NSRC-1:0] live;
	logic [2:0] top;
	logic [7:0] vec_mod;
	logic ack_win;
	logic rr23;
	logic mie;

	assign idle_ok = (st_r == ST_IDLE) && (rec_r == 3'h0);
	assign go_bus = idle_ok && !ack_a && cs_a && (rd_a || wr_a);
	assign go_ack = idle_ok && ack_a && rd_a;
	assign go = go_bus || go_ack;
	assign is_wr = !rd_a && wr_a;
	assign idx = dc ? IDX_BUF : ptr_r;
	assign ph = d_in[CMD_HI:CMD_LO] == CMD_POINT_HIGH;
	assign ptr_load = {ph, d_in[2:0]};
	assign wr_cmd = go_bus && is_wr && !dc && (ptr_r == IDX_CMD);
	assign int_rd = !dc && ((ptr_r == IDX_VEC) || (ptr_r == IDX_PEND));
	assign mie = mic_r[MIC_MIE];

	assign live = pend_r & ~svc_r;
	assign top = top_of(live);
	assign vec_mod = {vec_r[7:4], top, vec_r[0]};
	assign int_data = (ptr_r == IDX_VEC) ? (ab ? vec_r : vec_mod) :
		(ab ? {2'h0, pend_r} : 8'h00);
	assign ack_win = go_ack && chain_in && mie && (live != '0);
	assign rr23 = (ptr_r == IDX_VEC) || (ptr_r == IDX_PEND);

	// ----------------------------------------
	// Sequencer and recovery
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			st_r <= ST_IDLE;
			rec_r <= 3'h0;
		end else begin
			unique case (st_r)
				ST_IDLE: begin
					if (go) begin
						st_r <= ST_XFER;
					end
				end
				ST_XFER: begin
					st_r <= ST_HOLD;
				end
				ST_HOLD: begin
					// One access per strobe low
					if (!rd_a && !wr_a) begin
						st_r <= ST_IDLE;
					end
				end
				default: begin
					st_r <= ST_IDLE;
				end
			endcase
			if (go) begin
				rec_r <= RECOV_CYCLES - 3'h1;
			end else if (rec_r != 3'h0) begin
				rec_r <= rec_r - 3'h1;
			end
		end
	end

	// ----------------------------------------
	// Pointer and shared registers
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			ptr_r <= IDX_CMD;
			clr_ptr_r <= 1'b0;
			vec_r <= VEC_RESET;
			mic_r <= MIC_RESET;
		end else begin
			if (go_bus) begin
				clr_ptr_r <= !dc && !wr_cmd;
			end
			if (wr_cmd) begin
				ptr_r <= ptr_load;
			end else if (st_r == ST_XFER && clr_ptr_r) begin
				ptr_r <= IDX_CMD;
			end
			if (go_bus && is_wr && idx == IDX_VEC) begin
				vec_r <= d_in;
			end
			if (go_bus && is_wr && idx == IDX_MIC) begin
				mic_r <= d_in;
			end
		end
	end

	// ----------------------------------------
	// Channel register strobes
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			rrd_r <= 1'b0;
			rwr_r <= 1'b0;
			ridx_r <= IDX_CMD;
			rch_r <= 1'b0;
			rwd_r <= 8'h00;
			ext_rd_r <= 1'b0;
		end else begin
			rrd_r <= go_bus && rd_a && !int_rd;
			rwr_r <= go_bus && is_wr && idx != IDX_VEC && idx != IDX_MIC;
			ext_rd_r <= go_bus && rd_a && !int_rd;
			if (go_bus) begin
				ridx_r <= idx;
				rch_r <= ab;
				rwd_r <= d_in;
			end
		end
	end

	// ----------------------------------------
	// Data bus
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			dout_r <= 8'h00;
			doe_r <= 1'b0;
			ack_drv_r <= 1'b0;
		end else begin
			if (go_bus && rd_a && int_rd) begin
				dout_r <= int_data;
			end else if (st_r == ST_XFER && ext_rd_r) begin
				dout_r <= reg_rdata;
			end else if (ack_win) begin
				dout_r <= mic_r[MIC_VIS] ? vec_mod : vec_r;
			end
			if (ack_win) begin
				ack_drv_r <= 1'b1;
			end else if (!rd_a) begin
				ack_drv_r <= 1'b0;
			end
			doe_r <= rd_a && (ack_a ? (ack_drv_r || ack_win) : cs_a);
		end
	end

	// ----------------------------------------
	// Interrupt section
	// ----------------------------------------
	logic svc_clr;
	assign svc_clr = wr_cmd && d_in[CMD_HI:CMD_LO] == CMD_RESET_SVC;

	always_ff @(posedge clk) begin
		if (rst) begin
			tick_r <= 1'b0;
			pend_r <= PEND_RESET;
			svc_r <= PEND_RESET;
			irqn_r <= 1'b1;
			ceo_r <= 1'b1;
		end else begin
			// half rate, frozen on 2 and 3
			if (!rr23) begin
				tick_r <= !tick_r;
			end
			if (tick_r && !rr23) begin
				pend_r <= irq_src;
			end
			if (ack_win) begin
				svc_r <= svc_r | onehot(top);
			end else if (svc_clr && svc_r != '0) begin
				svc_r <= svc_r & ~onehot(top_of(svc_r));
			end
			irqn_r <= !(mie && live != '0 && svc_r == '0 && !ack_win);
			ceo_r <= chain_in && !mic_r[MIC_DLC] && svc_r == '0 && !(ack_a && live != '0);
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign d_out = dout_r;
	assign d_oe = doe_r;
	assign irq_n = irqn_r;
	assign chain_enable_out = ceo_r;
	assign reg_rd = rrd_r;
	assign reg_wr = rwr_r;
	assign reg_index = ridx_r;
	assign reg_chan = rch_r;
	assign reg_wdata = rwd_r;
	assign irq_pending_bits = pend_r;
	assign irq_in_service = svc_r;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_start;
		st_r == ST_IDLE && go;
	endsequence
	sequence s_quiet3;
		(st_r != ST_XFER) [*3];
	endsequence

	chk_recovery_spacing: assert property (@(posedge clk) disable iff (rst)
		s_start |=> ##1 s_quiet3)
		else $error("access started inside recovery");

	chk_strobe_needs_cs: assert property (@(posedge clk) disable iff (rst)
		(rrd_r || rwr_r) |-> $past(cs_a) && !$past(ack_a))
		else $error("register strobe without chip select");

	chk_drive_window: assert property (@(posedge clk) disable iff (rst)
		doe_r |-> $past(rd_a) && ($past(cs_a) || $past(ack_a)))
		else $error("data driven outside read");

	chk_pointer_clear: assert property (@(posedge clk) disable iff (rst)
		(go_bus && !dc && !wr_cmd) |=> ##1 ptr_r == IDX_CMD)
		else $error("pointer not cleared after control access");

	chk_data_keeps_ptr: assert property (@(posedge clk) disable iff (rst)
		(go_bus && dc) |=> $stable(ptr_r) ##1 $stable(ptr_r))
		else $error("data access moved the pointer");

	chk_pointer_load: assert property (@(posedge clk) disable iff (rst)
		wr_cmd |=> ptr_r == {$past(ph), $past(d_in[2:0])})
		else $error("pointer load wrong");

	chk_irq_release: assert property (@(posedge clk) disable iff (rst)
		ack_win |=> irqn_r && svc_r != '0)
		else $error("request not released after acknowledge");

	chk_tick_frozen: assert property (@(posedge clk) disable iff (rst)
		rr23 |=> $stable(tick_r) && $stable(pend_r))
		else $error("pending update while pointing at 2 or 3");

	chk_ack_no_write: assert property (@(posedge clk) disable iff (rst)
		ack_a |=> !rwr_r)
		else $error("write taken during acknowledge");
endmodule : host_port

// ### bench/host_bus_model.sv
// Host processor model driving the bus pins of the port
module host_bus_model (
	// Clock and read-back
	input wire logic clk,
	input wire logic [7:0] d_out,
	input wire logic d_oe,
	// Bus pins
	output logic cs_n,
	output logic rd_n,
	output logic wr_n,
	output logic dc_sel,
	output logic ab_sel,
	output logic irq_acknowledge_n,
	output logic [7:0] d_in
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam int HOLD = 10;
	localparam int GAP = 10;
	initial begin
		cs_n = 1'b1;
		rd_n = 1'b1;
		wr_n = 1'b1;
		dc_sel = 1'b0;
		ab_sel = 1'b0;
		irq_acknowledge_n = 1'b1;
		d_in = 8'h00;
	end
	task automatic access(input logic rd, input logic dc, input logic ab, input logic sel,
		input logic [7:0] d, output logic [7:0] q, output logic oe);
		@(negedge clk);
		dc_sel = dc;
		ab_sel = ab;
		d_in = d;
		@(negedge clk);
		cs_n = !sel;
		rd_n = !rd;
		wr_n = rd;
		repeat (HOLD) @(negedge clk);
		q = d_out;
		oe = d_oe;
		cs_n = 1'b1;
		rd_n = 1'b1;
		wr_n = 1'b1;
		// Released bus must not look driven
		d_in = ~d;
		repeat (GAP) @(negedge clk);
	endtask : access
	task automatic ack_read(input logic wr, output logic [7:0] q, output logic oe);
		@(negedge clk);
		irq_acknowledge_n = 1'b0;
		repeat (8) @(negedge clk);
		rd_n = 1'b0;
		wr_n = !wr;
		cs_n = !wr;
		repeat (HOLD) @(negedge clk);
		q = d_out;
		oe = d_oe;
		rd_n = 1'b1;
		wr_n = 1'b1;
		cs_n = 1'b1;
		irq_acknowledge_n = 1'b1;
		repeat (GAP) @(negedge clk);
	endtask : ack_read
endmodule : host_bus_model

// ### bench/serial_ctrl_host_bus_port_tb_top.sv
// Self-checking bench for the processor bus port
module serial_ctrl_host_bus_port_tb_top
	import host_port_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk, rst, cs_n, rd_n, wr_n, dc_sel, ab_sel, ack_n, chain_enable_in;
	logic d_oe, irq_n, chain_enable_out, reg_rd, reg_wr, reg_chan, oe, w_chan;
	logic [7:0] d_in, d_out, reg_wdata, reg_rdata, q, w_idx, w_data, r_idx;
	logic [3:0] reg_index;
	logic [NSRC-1:0] irq_src, irq_pending_bits, irq_in_service;
	int wr_cnt = 0;
	int rd_cnt = 0;
	int n_mismatch = 0;
	int cmp_count = 0;
	// Read data tagged with channel and index
	assign reg_rdata = {3'h5, reg_chan, reg_index};
	host_port dut (.clk(clk), .rst(rst), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
		.dc_sel(dc_sel), .ab_sel(ab_sel), .irq_acknowledge_n(ack_n),
		.chain_enable_in(chain_enable_in), .d_in(d_in), .d_out(d_out), .d_oe(d_oe),
		.irq_n(irq_n), .chain_enable_out(chain_enable_out), .reg_rd(reg_rd),
		.reg_wr(reg_wr), .reg_index(reg_index), .reg_chan(reg_chan),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .irq_src(irq_src),
		.irq_pending_bits(irq_pending_bits), .irq_in_service(irq_in_service));
	host_bus_model host (.clk(clk), .d_out(d_out), .d_oe(d_oe), .cs_n(cs_n),
		.rd_n(rd_n), .wr_n(wr_n), .dc_sel(dc_sel), .ab_sel(ab_sel),
		.irq_acknowledge_n(ack_n), .d_in(d_in));
	always @(negedge clk) begin
		if (reg_wr === 1'b1) begin
			wr_cnt++;
			w_idx = {4'h0, reg_index};
			w_chan = reg_chan;
			w_data = reg_wdata;
		end
		if (reg_rd === 1'b1) begin
			rd_cnt++;
			r_idx = {4'h0, reg_index};
		end
	end
	// ----
	// Compare and closing tasks
	// ----
	task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_val
	task automatic chk_bit(input logic got, input logic exp);
		chk_val({7'h00, got}, {7'h00, exp});
	endtask : chk_bit
	task automatic test_done();
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : test_done
	// ----
	// Scenarios
	// ----
	task automatic t_no_select();
		int n0;
		n0 = wr_cnt + rd_cnt;
		chk_bit(d_oe, 1'b0);
		host.access(1'b1, 1'b0, 1'b1, 1'b0, 8'h00, q, oe);
		chk_bit(oe, 1'b0);
		host.access(1'b0, 1'b0, 1'b1, 1'b0, 8'h11, q, oe);
		chk_val(8'(wr_cnt + rd_cnt - n0), 8'h00);
		$display("t_no_select done");
	endtask : t_no_select
	task automatic t_pointer();
		host.access(1'b0, 1'b0, 1'b0, 1'b1, 8'h05, q, oe);
		chk_val(w_idx, 8'h00);
		host.access(1'b0, 1'b0, 1'b1, 1'b1, 8'hA5, q, oe);
		chk_val(w_idx, 8'h05);
		chk_bit(w_chan, 1'b1);
		chk_val(w_data, 8'hA5);
		host.access(1'b0, 1'b0, 1'b1, 1'b1, 8'h40, q, oe);
		chk_val(w_idx, 8'h00);
		$display("t_pointer done");
	endtask : t_pointer
	task automatic t_data_sel();
		host.access(1'b0, 1'b0, 1'b1, 1'b1, 8'h06, q, oe);
		host.access(1'b0, 1'b1, 1'b0, 1'b1, 8'h3C, q, oe);
		chk_val(w_idx, 8'h08);
		chk_val(w_data, 8'h3C);
		host.access(1'b1, 1'b0, 1'b1, 1'b1, 8'h00, q, oe);
		chk_val(r_idx, 8'h06);
		chk_val(q, 8'hB6);
		chk_bit(oe, 1'b1);
		host.access(1'b1, 1'b0, 1'b0, 1'b1, 8'h00, q, oe);
		chk_val(r_idx, 8'h00);
		chk_val(q, 8'hA0);
		chk_bit(d_oe, 1'b0);
		$display("t_data_sel done");
	endtask : t_data_sel
	task automatic t_point_high();
		host.access(1'b0, 1'b0, 1'b1, 1'b1, 8'h08, q, oe);
		host.access(1'b1, 1'b0, 1'b0, 1'b1, 8'h00, q, oe);
		chk_val(r_idx, 8'h08);
		chk_val(q, 8'hA8);
		host.access(1'b0, 1'b0, 1'b1, 1'b1, 8'h0D, q, oe);
		host.access(1'b0, 1'b0, 1'b1, 1'b1, 8'h77, q, oe);
		chk_val(w_idx, 8'h0D);
		$display("t_point_high done");
	endtask : t_point_high
	task automatic t_ack();
		int n0;
		host.access(1'b0, 1'b0, 1'b1, 1'b1, 8'h09, q, oe);
		host.access(1'b0, 1'b0, 1'b0, 1'b1, 8'h08, q, oe);
		host.access(1'b0, 1'b0, 1'b0, 1'b1, 8'h02, q, oe);
		host.access(1'b0, 1'b0, 1'b1, 1'b1, 8'h50, q, oe);
		irq_src = 6'h20;
		for (int i = 0; i < 60 && irq_n !== 1'b0; i++) @(negedge clk);
		chk_bit(irq_n, 1'b0);
		if (irq_n !== 1'b0) test_done();
		chk_val({2'h0, irq_pending_bits}, 8'h20);
		host.access(1'b1, 1'b1, 1'b0, 1'b1, 8'h00, q, oe);
		chk_val(q, 8'hA8);
		n0 = wr_cnt + rd_cnt;
		host.ack_read(1'b1, q, oe);
		chk_val(q, 8'h50);
		chk_bit(oe, 1'b1);
		chk_val({2'h0, irq_in_service}, 8'h20);
		chk_bit(irq_n, 1'b1);
		chk_bit(chain_enable_out, 1'b0);
		chk_val(8'(wr_cnt + rd_cnt - n0), 8'h00);
		irq_src = 6'h00;
		host.access(1'b0, 1'b0, 1'b1, 1'b1, 8'h38, q, oe);
		chk_val({2'h0, irq_in_service}, 8'h00);
		chk_bit(chain_enable_out, 1'b1);
		$display("t_ack done");
	endtask : t_ack
	initial begin
		clk = 1'b0;
		forever #(CLK_PERIOD_NS / 2.0) clk = ~clk;
	end
	initial begin
		rst = 1'b1;
		chain_enable_in = 1'b1;
		irq_src = 6'h00;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		repeat (6) @(negedge clk);
		t_no_select();
		t_pointer();
		t_data_sel();
		t_point_high();
		t_ack();
		test_done();
	end
endmodule : serial_ctrl_host_bus_port_tb_top
